// [cmd_pkg.sv]
// package: command codes, field layouts and reset values for the command decoder
package cmd_pkg;

  // command bytes
  localparam logic [7:0] CMD_RMW_ENTER = 8'he0;
  localparam logic [7:0] CMD_RMW_END = 8'hee;
  localparam logic [7:0] CMD_SOFT_RESET = 8'he2;
  localparam logic [7:0] CMD_NOP = 8'he3;
  localparam logic [7:0] CMD_BIAS_BASE = 8'ha2;
  localparam logic [7:0] CMD_ALLON_BASE = 8'ha4;
  localparam logic [7:0] CMD_DISP_BASE = 8'hae;
  // pattern masks and matches
  localparam logic [7:0] MASK_TOP5 = 8'hf8;
  localparam logic [7:0] MASK_TOP3 = 8'he0;
  localparam logic [7:0] MASK_TOP7 = 8'hfe;
  localparam logic [7:0] MASK_TEST = 8'hd0;
  localparam logic [7:0] PAT_POWER = 8'h28;
  localparam logic [7:0] PAT_RATIO = 8'h20;
  localparam logic [7:0] PAT_VOLUME = 8'h80;
  localparam logic [7:0] PAT_TEST = 8'hd0;

  // widths and limits
  localparam int COL_W = 7;
  localparam logic [6:0] COL_LAST = 7'h65;

  // reset values of the mode settings
  localparam logic [2:0] RST_POWER = 3'h0;
  localparam logic [2:0] RST_RATIO = 3'h0;
  localparam logic [4:0] RST_VOLUME = 5'h00;
  localparam logic RST_BIAS = 1'b0;
  localparam logic RST_DISP_ON = 1'b0;
  localparam logic RST_ALL_ON = 1'b0;
  localparam logic [6:0] RST_COL = 7'h00;
  // derived outputs: drive grounded, discharge on, oscillator running
  localparam logic [4:0] RST_ALPHA = 5'h1f;
  localparam logic RST_SAVER = 1'b0;
  localparam logic RST_OSC = 1'b1;
  localparam logic RST_SUPPLY = 1'b0;
  localparam logic RST_GROUND = 1'b1;
  localparam logic RST_BIAS_APP = 1'b0;
  localparam logic RST_DISCHARGE = 1'b1;

  // decoded settings that travel together
  typedef struct packed {
    logic booster_en;
    logic regulator_en;
    logic follower_en;
  } power_t;

  typedef struct packed {
    logic [2:0] regulator_ratio;
    logic [4:0] volume;
    logic bias_sel;
  } drive_t;

  // read-modify-write state, gray along idle -> active
  typedef enum logic [0:0] {
    RMW_IDLE = 1'b0,
    RMW_ACTIVE = 1'b1
  } rmw_state_t;

endpackage

// [column_counter.sv]
// column address counter with save and restore for read-modify-write
`timescale 1ns/100ps
module column_counter (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic col_load,
  input wire logic [6:0] col_load_val,
  input wire logic rd_step,
  input wire logic wr_step,
  input wire logic rmw_active,
  input wire logic save,
  input wire logic restore,
  output logic [6:0] col
);
  logic [6:0] col_r;
  logic [6:0] col_nxt;
  logic [6:0] saved_r;
  wire logic step;
  wire logic [6:0] col_inc;

  // reads hold the column in rmw, writes always advance
  assign step = wr_step | (rd_step & ~rmw_active);
  assign col_inc = (col_r == cmd_pkg::COL_LAST) ? 7'h00 : col_r + 7'h01;

  // restore wins over access, since end arrives on its own cycle
  always_comb begin
    col_nxt = col_r;
    if (soft_rst) begin
      col_nxt = cmd_pkg::RST_COL;
    end else if (restore) begin
      col_nxt = saved_r;
    end else if (col_load) begin
      col_nxt = col_load_val;
    end else if (step) begin
      col_nxt = col_inc;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      col_r <= cmd_pkg::RST_COL;
      saved_r <= cmd_pkg::RST_COL;
    end else begin
      col_r <= col_nxt;
      if (save) begin
        saved_r <= col_r;
      end
    end
  end

  assign col = col_r;
endmodule

// [cmd_decoder.sv]
// command decoder: read-modify-write, power control, drive level, power saver
`timescale 1ns/100ps
// What this block does
// - 0xE0 saves column, reads then hold column
// - End leaves mode and restores saved column
// - 0xEE with command select low is End
// - only column restored, page keeps its value
// - other commands work normally during rmw
// - 00101xyz sets booster, regulator, follower enables
// - 00100xyz loads three-bit regulator ratio
// - 100xxxxx loads volume, alpha is inverse
// - 0xA2/0xA3 select 1/8 or 1/6 bias
// - bias applies only while follower enabled
// - all-on while display off enters power saver
// - saver stops oscillator and drive supply
// - saver stops drivers, outputs to ground
// - saver keeps settings, host access continues
// - 0xE2 reinitialises state, keeps display RAM
// - soft reset never triggers discharge paths
// - test state left by resets or display on/off
module cmd_decoder (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hw_reset_n,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic cmd_data_select,
  input wire logic [7:0] bus_data,
  input wire logic col_load,
  input wire logic [6:0] col_load_val,
  output logic [6:0] col_addr,
  output logic rmw_active,
  output logic booster_en,
  output logic regulator_en,
  output logic follower_en,
  output logic [2:0] regulator_ratio,
  output logic [4:0] volume,
  output logic [4:0] alpha,
  output logic bias_sel,
  output logic bias_applied,
  output logic display_on,
  output logic all_points_on,
  output logic power_saver,
  output logic osc_run,
  output logic supply_run,
  output logic driver_ground,
  output logic discharge_en,
  output logic test_state
);
  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire logic cmd_wr;
  wire logic hit_rmw;
  wire logic hit_end;
  wire logic hit_reset;
  wire logic hit_power;
  wire logic hit_ratio;
  wire logic hit_volume;
  wire logic hit_bias;
  wire logic hit_allon;
  wire logic hit_disp;
  wire logic hit_test;
  wire logic data_wr;
  wire logic data_rd;

  // command/data select low on a write marks a command byte
  assign cmd_wr = bus_wr & ~cmd_data_select;
  // display RAM accesses move only the column
  assign data_wr = bus_wr & cmd_data_select;
  assign data_rd = bus_rd & cmd_data_select;
  // rmw, end and soft reset match whole bytes
  assign hit_rmw = cmd_wr & (bus_data == cmd_pkg::CMD_RMW_ENTER);
  assign hit_end = cmd_wr & (bus_data == cmd_pkg::CMD_RMW_END);
  assign hit_reset = cmd_wr & (bus_data == cmd_pkg::CMD_SOFT_RESET);
  // setting loads match on their fixed upper bits
  assign hit_power = cmd_wr & ((bus_data & cmd_pkg::MASK_TOP5) == cmd_pkg::PAT_POWER);
  assign hit_ratio = cmd_wr & ((bus_data & cmd_pkg::MASK_TOP5) == cmd_pkg::PAT_RATIO);
  assign hit_volume = cmd_wr & ((bus_data & cmd_pkg::MASK_TOP3) == cmd_pkg::PAT_VOLUME);
  assign hit_bias = cmd_wr & ((bus_data & cmd_pkg::MASK_TOP7) == cmd_pkg::CMD_BIAS_BASE);
  // display controls, which also feed the power saver
  assign hit_allon = cmd_wr & ((bus_data & cmd_pkg::MASK_TOP7) == cmd_pkg::CMD_ALLON_BASE);
  assign hit_disp = cmd_wr & ((bus_data & cmd_pkg::MASK_TOP7) == cmd_pkg::CMD_DISP_BASE);
  // the test pattern overlaps e0/e2/e3/ee only where bit 4 is set, so no clash
  assign hit_test = cmd_wr & ((bus_data & cmd_pkg::MASK_TEST) == cmd_pkg::PAT_TEST);
  // nop (e3) matches no hit term above and so changes nothing

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  cmd_pkg::rmw_state_t rmw_r;
  cmd_pkg::rmw_state_t rmw_nxt;
  cmd_pkg::power_t power_r;
  cmd_pkg::power_t power_nxt;
  cmd_pkg::drive_t drive_r;
  cmd_pkg::drive_t drive_nxt;
  logic disp_on_r;
  logic disp_on_nxt;
  logic all_on_r;
  logic all_on_nxt;
  logic test_r;
  logic test_nxt;
  logic saver_r;
  logic discharge_r;
  logic bias_app_r;
  logic osc_r;
  logic supply_r;
  logic gnd_r;
  logic [4:0] alpha_r;
  wire logic saver_now;

  // rmw mode: enter on e0, leave on end or soft reset
  // a second e0 inside the mode is ignored, so the first saved column survives
  always_comb begin
    case (rmw_r)
      cmd_pkg::RMW_IDLE: rmw_nxt = hit_rmw ? cmd_pkg::RMW_ACTIVE : cmd_pkg::RMW_IDLE;
      cmd_pkg::RMW_ACTIVE: rmw_nxt = hit_end ? cmd_pkg::RMW_IDLE : cmd_pkg::RMW_ACTIVE;
      default: rmw_nxt = cmd_pkg::RMW_IDLE;
    endcase
    if (hit_reset) begin
      rmw_nxt = cmd_pkg::RMW_IDLE;
    end
  end

  // mode settings; other commands decode the same in rmw mode
  always_comb begin
    power_nxt = power_r;
    drive_nxt = drive_r;
    disp_on_nxt = disp_on_r;
    all_on_nxt = all_on_r;
    if (hit_reset) begin
      power_nxt = cmd_pkg::RST_POWER;
      drive_nxt = {cmd_pkg::RST_RATIO, cmd_pkg::RST_VOLUME, cmd_pkg::RST_BIAS};
      disp_on_nxt = cmd_pkg::RST_DISP_ON;
      all_on_nxt = cmd_pkg::RST_ALL_ON;
    end else begin
      if (hit_power) begin
        power_nxt = {bus_data[2], bus_data[1], bus_data[0]};
      end
      if (hit_ratio) begin
        drive_nxt.regulator_ratio = bus_data[2:0];
      end
      if (hit_volume) begin
        drive_nxt.volume = bus_data[4:0];
      end
      if (hit_bias) begin
        drive_nxt.bias_sel = bus_data[0];
      end
      if (hit_allon) begin
        all_on_nxt = bus_data[0];
      end
      if (hit_disp) begin
        disp_on_nxt = bus_data[0];
      end
    end
  end

  // test state is sticky until reset pin, soft reset or display on/off
  // clear before set; one byte can never be both, so the order is only a guard
  always_comb begin
    test_nxt = test_r;
    if (hit_reset | hit_disp) begin
      test_nxt = 1'b0;
    end else if (hit_test) begin
      test_nxt = 1'b1;
    end
  end

  // saver is the compound of display off and all points on, in either order
  assign saver_now = ~disp_on_nxt & all_on_nxt;

  // rmw and test state; the hardware pin clears them synchronously
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rmw_r <= cmd_pkg::RMW_IDLE;
      test_r <= 1'b0;
    end else if (~hw_reset_n) begin
      rmw_r <= cmd_pkg::RMW_IDLE;
      test_r <= 1'b0;
    end else begin
      rmw_r <= rmw_nxt;
      test_r <= test_nxt;
    end
  end

  // mode settings; the pin returns them to their reset values as well
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      power_r <= cmd_pkg::RST_POWER;
      drive_r <= {cmd_pkg::RST_RATIO, cmd_pkg::RST_VOLUME, cmd_pkg::RST_BIAS};
      disp_on_r <= cmd_pkg::RST_DISP_ON;
      all_on_r <= cmd_pkg::RST_ALL_ON;
    end else if (~hw_reset_n) begin
      power_r <= cmd_pkg::RST_POWER;
      drive_r <= {cmd_pkg::RST_RATIO, cmd_pkg::RST_VOLUME, cmd_pkg::RST_BIAS};
      disp_on_r <= cmd_pkg::RST_DISP_ON;
      all_on_r <= cmd_pkg::RST_ALL_ON;
    end else begin
      power_r <= power_nxt;
      drive_r <= drive_nxt;
      disp_on_r <= disp_on_nxt;
      all_on_r <= all_on_nxt;
    end
  end

  // ----------------------------------------------------------------
  // derived outputs, each registered
  // ----------------------------------------------------------------
  // next values look at next settings, so outputs agree with state at once
  wire logic saver_nxt;
  wire logic osc_nxt;
  wire logic supply_nxt;
  wire logic gnd_nxt;
  wire logic bias_app_nxt;
  wire logic [4:0] alpha_nxt;
  wire logic discharge_nxt;

  // a low pin forces each of these to its reset level
  assign saver_nxt = saver_now & hw_reset_n;
  assign osc_nxt = ~saver_nxt;
  assign supply_nxt = hw_reset_n & ~saver_now & (|power_nxt);
  assign gnd_nxt = ~hw_reset_n | saver_now | ~disp_on_nxt;
  assign bias_app_nxt = hw_reset_n & power_nxt.follower_en & drive_nxt.bias_sel;
  assign alpha_nxt = hw_reset_n ? ~drive_nxt.volume : cmd_pkg::RST_ALPHA;
  // only the pin drives discharge; soft reset has no path here
  assign discharge_nxt = ~hw_reset_n;

  // power saver and its run enables; the settings themselves stay put
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      saver_r <= cmd_pkg::RST_SAVER;
      osc_r <= cmd_pkg::RST_OSC;
      supply_r <= cmd_pkg::RST_SUPPLY;
      gnd_r <= cmd_pkg::RST_GROUND;
    end else begin
      saver_r <= saver_nxt;
      osc_r <= osc_nxt;
      supply_r <= supply_nxt;
      gnd_r <= gnd_nxt;
    end
  end

  // drive level seen by the regulator; alpha is kept inverted here
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bias_app_r <= cmd_pkg::RST_BIAS_APP;
      alpha_r <= cmd_pkg::RST_ALPHA;
    end else begin
      bias_app_r <= bias_app_nxt;
      alpha_r <= alpha_nxt;
    end
  end

  // discharge lags the pin by one edge, the price of a registered output
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      discharge_r <= cmd_pkg::RST_DISCHARGE;
    end else begin
      discharge_r <= discharge_nxt;
    end
  end

  // ----------------------------------------------------------------
  // column counter
  // ----------------------------------------------------------------
  // page address is outside this block and is never restored
  // restore outranks load and step, so end lands on the saved column unless the pin is low in that cycle
  column_counter u_col (
    .ref_clk(ref_clk),
    .rst(rst),
    .soft_rst(hit_reset | ~hw_reset_n),
    .col_load(col_load),
    .col_load_val(col_load_val),
    .rd_step(data_rd),
    .wr_step(data_wr),
    .rmw_active(rmw_r == cmd_pkg::RMW_ACTIVE),
    .save(hit_rmw & (rmw_r == cmd_pkg::RMW_IDLE)),
    .restore(hit_end & (rmw_r == cmd_pkg::RMW_ACTIVE)),
    .col(col_addr)
  );

  // outputs: each is a register bit, no logic after the flop
  assign rmw_active = (rmw_r == cmd_pkg::RMW_ACTIVE);
  assign booster_en = power_r.booster_en;
  assign regulator_en = power_r.regulator_en;
  assign follower_en = power_r.follower_en;
  assign regulator_ratio = drive_r.regulator_ratio;
  assign volume = drive_r.volume;
  assign alpha = alpha_r;
  assign bias_sel = drive_r.bias_sel;
  assign bias_applied = bias_app_r;
  assign display_on = disp_on_r;
  assign all_points_on = all_on_r;

  // power saver and its run enables, then discharge and test state
  assign power_saver = saver_r;
  assign osc_run = osc_r;
  assign supply_run = supply_r;
  assign driver_ground = gnd_r;
  assign discharge_en = discharge_r;
  assign test_state = test_r;
endmodule

// [cmd_decoder_properties.sv]
// checker: timing relations of the command decoder outputs
`timescale 1ns/100ps
module cmd_decoder_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hw_reset_n,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic cmd_data_select,
  input wire logic [7:0] bus_data,
  input wire logic col_load,
  input wire logic [6:0] col_addr,
  input wire logic rmw_active,
  input wire logic booster_en,
  input wire logic regulator_en,
  input wire logic follower_en,
  input wire logic [4:0] volume,
  input wire logic [4:0] alpha,
  input wire logic bias_sel,
  input wire logic bias_applied,
  input wire logic power_saver,
  input wire logic osc_run,
  input wire logic driver_ground,
  input wire logic discharge_en,
  input wire logic test_state
);
  // ---
  // helpers
  // ---
  // a command byte taken this edge; a low pin swallows it
  wire cmd_wr = bus_wr && !cmd_data_select && hw_reset_n;
  logic [6:0] saved_r;
  // column as it stood when the mode began, held here to judge the restore
  always_ff @(posedge ref_clk) begin
    if (cmd_wr && bus_data == 8'he0 && !rmw_active) begin
      saved_r <= col_addr;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_enter;
    cmd_wr && bus_data == 8'he0 && !rmw_active;
  endsequence
  sequence s_end;
    cmd_wr && bus_data == 8'hee && rmw_active;
  endsequence
  // ---
  // properties
  // ---
  a_rmw_enter: assert property (s_enter |=> rmw_active)
    else $error("rmw mode not entered");
  a_read_hold: assert property (rmw_active && bus_rd && cmd_data_select && !bus_wr
    && !col_load && hw_reset_n |=> col_addr == $past(col_addr))
    else $error("column moved on rmw read");
  a_end_restore: assert property (s_end |=> !rmw_active && col_addr == saved_r)
    else $error("end did not restore column");
  a_power_bits: assert property (cmd_wr && (bus_data & 8'hf8) == 8'h28 |=>
    {booster_en, regulator_en, follower_en} == $past(bus_data[2:0]))
    else $error("power enables wrong");
  a_volume_alpha: assert property (cmd_wr && bus_data[7:5] == 3'h4 |=>
    volume == $past(bus_data[4:0]) && alpha == ~volume)
    else $error("volume or alpha wrong");
  a_bias_gate: assert property (cmd_wr && bus_data[7:1] == 7'h51 |=>
    bias_sel == $past(bus_data[0]) && bias_applied == (bias_sel && follower_en))
    else $error("bias selection wrong");
  a_saver_off: assert property (power_saver |-> !osc_run && driver_ground)
    else $error("saver left circuits running");
  a_soft_reset: assert property (cmd_wr && bus_data == 8'he2 |=>
    !discharge_en && !rmw_active && !test_state)
    else $error("soft reset effect wrong");
  a_test_exit: assert property (test_state && cmd_wr && bus_data[7:1] == 7'h57 |=> !test_state)
    else $error("test state kept after display cmd");
endmodule
bind cmd_decoder cmd_decoder_properties u_props (.ref_clk, .rst, .hw_reset_n, .bus_wr, .bus_rd,
  .cmd_data_select, .bus_data, .col_load, .col_addr, .rmw_active, .booster_en, .regulator_en,
  .follower_en, .volume, .alpha, .bias_sel, .bias_applied, .power_saver, .osc_run,
  .driver_ground, .discharge_en, .test_state);

// [host_model.sv]
// host processor model: drives command and data bytes on the parallel bus
`timescale 1ns/100ps
module host_model (
  input wire logic ref_clk,
  output logic bus_wr,
  output logic bus_rd,
  output logic cmd_data_select,
  output logic [7:0] bus_data,
  output logic col_load,
  output logic [6:0] col_load_val
);
  // ---
  // bus tasks
  // ---
  // quiet bus until the first access
  initial begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    cmd_data_select = 1'b0;
    bus_data = 8'h00;
    col_load = 1'b0;
    col_load_val = 7'h00;
  end
  // one access per cycle; it stands over the taking edge, so calls may run back to back
  task automatic put(input logic w, input logic r, input logic s, input logic [7:0] d);
    @(negedge ref_clk);
    col_load = 1'b0;
    bus_wr = w;
    bus_rd = r;
    cmd_data_select = s;
    bus_data = d;
  endtask
  // page set is not modelled; after passing 65h the host sets it again
  // column set from outside; never issued while rmw runs
  task automatic ld(input logic [6:0] v);
    @(negedge ref_clk);
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    col_load = 1'b1;
    col_load_val = v;
  endtask
  // release: data lines flip so a stale byte can never pass for a fresh one
  task automatic idle();
    @(negedge ref_clk);
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    col_load = 1'b0;
    bus_data = ~bus_data;
  endtask
endmodule

// [testbench.sv]
// testbench: command sequences with expected settings for the command decoder
`timescale 1ns/100ps
module testbench;
  logic ref_clk, rst, hw_reset_n, bus_wr, bus_rd, cmd_data_select, col_load, rmw_active;
  logic [7:0] bus_data;
  logic [6:0] col_load_val, col_addr;
  logic booster_en, regulator_en, follower_en, bias_sel, bias_applied, display_on;
  logic all_points_on, power_saver, osc_run, supply_run, driver_ground, discharge_en, test_state;
  logic [2:0] regulator_ratio;
  logic [4:0] volume, alpha;
  int n_mismatch, checks_done;
  // ---
  // clock, design and host
  // ---
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  cmd_decoder DUT (.ref_clk, .rst, .hw_reset_n, .bus_wr, .bus_rd, .cmd_data_select, .bus_data,
    .col_load, .col_load_val, .col_addr, .rmw_active, .booster_en, .regulator_en, .follower_en,
    .regulator_ratio, .volume, .alpha, .bias_sel, .bias_applied, .display_on, .all_points_on,
    .power_saver, .osc_run, .supply_run, .driver_ground, .discharge_en, .test_state);
  host_model h (.ref_clk, .bus_wr, .bus_rd, .cmd_data_select, .bus_data, .col_load, .col_load_val);
  // ---
  // tasks
  // ---
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // single command, then a released bus so the effect is settled at the check
  task automatic cmd(input logic [7:0] b);
    h.put(1'b1, 1'b0, 1'b0, b);
    h.idle();
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    test_done();
  end
  // ---
  // sequence
  // ---
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    rst = 1'b1;
    hw_reset_n = 1'b0; // pin reset at power-up
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    hw_reset_n = 1'b1;
    h.idle();
    chk(8'(alpha), 8'h1f);
    chk(8'(osc_run), 8'h01);
    // rmw across the last column: writes step and wrap, reads hold
    h.ld(7'h64);
    h.put(1'b1, 1'b0, 1'b0, 8'he0);
    h.put(1'b1, 1'b0, 1'b1, 8'h5a);
    h.put(1'b1, 1'b0, 1'b1, 8'h5b);
    h.put(1'b0, 1'b1, 1'b1, 8'h00);
    h.put(1'b1, 1'b0, 1'b0, 8'h2d);
    h.idle();
    chk(8'(col_addr), 8'h00);
    chk(8'({booster_en, regulator_en, follower_en}), 8'h05);
    cmd(8'hee);
    chk(8'({rmw_active, col_addr}), 8'h64);
    cmd(8'hee);
    chk(8'({rmw_active, col_addr}), 8'h64);
    for (int i = 0; i < 8; i++) begin
      cmd(8'h28 | 8'(i));
      chk(8'({booster_en, regulator_en, follower_en}), 8'(i));
      cmd(8'h20 | 8'(i));
      chk(8'(regulator_ratio), 8'(i));
    end
    for (int i = 0; i < 32; i += 31) begin
      cmd(8'h80 | 8'(i));
      chk(8'(volume), 8'(i));
      chk(8'(alpha), 8'(31 - i));
    end
    // bias is stored with the follower off but only applied once it runs
    cmd(8'h28);
    cmd(8'ha3);
    chk(8'({bias_sel, bias_applied}), 8'h02);
    cmd(8'h29);
    chk(8'({bias_sel, bias_applied}), 8'h03);
    cmd(8'ha2);
    chk(8'({bias_sel, bias_applied}), 8'h00);
    // display off then all points on
    cmd(8'hae);
    cmd(8'ha5);
    chk(8'({power_saver, osc_run, supply_run, driver_ground}), 8'h09);
    chk(8'({display_on, all_points_on}), 8'h01);
    chk(8'(volume), 8'h1f);
    cmd(8'h83);
    chk(8'({regulator_ratio, volume}), 8'he3);
    cmd(8'he3);
    chk(8'({power_saver, regulator_ratio, volume[3:0]}), 8'hf3);
    // display on ends the saver, then all points back to normal
    cmd(8'haf);
    chk(8'({power_saver, osc_run, supply_run, driver_ground}), 8'h06);
    cmd(8'ha4);
    chk(8'({display_on, all_points_on}), 8'h02);
    // test bytes sent on purpose to exercise the way out
    cmd(8'hd0);
    chk(8'(test_state), 8'h01);
    cmd(8'hae);
    chk(8'(test_state), 8'h00);
    cmd(8'hf5);
    cmd(8'he2);
    chk(8'({test_state, discharge_en, rmw_active}), 8'h00);
    chk(8'(volume), 8'h00);
    chk(8'(col_addr), 8'h00);
    cmd(8'hd0);
    hw_reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(8'({test_state, discharge_en}), 8'h01);
    hw_reset_n = 1'b1;
    h.idle();
    chk(8'(discharge_en), 8'h00);
    // settings refreshed after the pin, as a host does from time to time
    cmd(8'h2f);
    chk(8'({booster_en, regulator_en, follower_en}), 8'h07);
    test_done();
  end
endmodule
